// ---- design/irqpu_pkg.sv ----
// ****************************************************************
// Shared constants of the interrupt request and priority unit
// ****************************************************************
package irqpu_pkg;
    // Register addresses on the special function register port
    localparam logic [7:0] ADDR_TIMER_IRQ_CONTROL = 8'h88;
    localparam logic [7:0] ADDR_IRQ_ENABLE_MASK = 8'hA8;
    localparam logic [7:0] ADDR_IRQ_PRIORITY_SELECT = 8'hB8;

    // Timer and interrupt control bit positions
    localparam int CTRL_EXT0_TRIG = 0;
    localparam int CTRL_EXT0_FLAG = 1;
    localparam int CTRL_EXT1_TRIG = 2;
    localparam int CTRL_EXT1_FLAG = 3;
    localparam int CTRL_TIMER0_RUN = 4;
    localparam int CTRL_TIMER0_OVF = 5;
    localparam int CTRL_TIMER1_RUN = 6;
    localparam int CTRL_TIMER1_OVF = 7;

    // Enable and priority register layout
    localparam int NUM_SRC = 6;
    localparam int BIT_RESERVED = 6;
    localparam int BIT_TOP = 7;

    // Source order, which is also the fixed tie-break order
    localparam logic [2:0] SRC_EXT0 = 3'h0;
    localparam logic [2:0] SRC_TIMER0 = 3'h1;
    localparam logic [2:0] SRC_EXT1 = 3'h2;
    localparam logic [2:0] SRC_TIMER1 = 3'h3;
    localparam logic [2:0] SRC_UART = 3'h4;
    localparam logic [2:0] SRC_TIMER2 = 3'h5;

    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] PRIO_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // Program addresses
    localparam logic [15:0] RESET_START = 16'h0000;
    localparam logic [15:0] VECTOR_BASE = 16'h0003;
    localparam int VECTOR_SHIFT = 3;

    // Serial modes with a ninth data bit have the top mode bit set
    localparam int UART_MODE_9BIT = 1;
endpackage

// ---- design/irqpu_top.sv ----
`timescale 1ns/100ps
module irqpu_top (
    input wire logic SYS_CLK, // System clock
    input wire logic RESET, // Synchronous reset, active high
    input wire logic [7:0] SFR_ADDR, // Register address
    input wire logic SFR_WR, // Register write strobe
    input wire logic [7:0] SFR_WDATA, // Register write data
    input wire logic SFR_RD, // Register read strobe
    output logic [7:0] SFR_RDATA, // Register read data, one cycle later
    input wire logic EXT_IRQ0_PIN_N, // External interrupt 0, active low
    input wire logic EXT_IRQ1_PIN_N, // External interrupt 1, active low
    input wire logic TIMER0_CARRY, // Timer 0 carry pulse
    input wire logic TIMER1_CARRY, // Timer 1 carry pulse
    input wire logic TIMER2_CARRY, // Timer 2 carry pulse
    input wire logic TIMER2_TRIGGER_PIN, // Timer 2 trigger input
    input wire logic TIMER2_EXT_EVENT_ENABLE, // Trigger input enable
    input wire logic TIMER2_OVF_CLR, // Software clear of timer 2 overflow flag
    input wire logic TIMER2_EXT_CLR, // Software clear of timer 2 event flag
    input wire logic UART_RX_EVENT, // Receive complete pulse
    input wire logic UART_RX_NINTH_BIT, // Received ninth bit
    input wire logic UART_MULTIPROC_FILTER, // Multiprocessor filter enable
    input wire logic [1:0] UART_MODE, // Serial port mode
    input wire logic UART_RX_CLR, // Software clear of receive flag
    input wire logic UART_TX_EVENT, // Last bit sent pulse
    input wire logic UART_TX_CLR, // Software clear of transmit flag
    input wire logic IRQ_ACK, // Core accepts presented vector
    input wire logic IRQ_RETURN, // Core returns from service routine
    output logic IRQ_REQ, // Interrupt request to core
    output logic [15:0] IRQ_VECTOR, // Vector address of request
    output logic IDLE_WAKE, // Pulse ending idle state
    output logic [15:0] RESET_VECTOR, // Start address after reset
    output logic TIMER0_RUN, // Timer 0 run control
    output logic TIMER1_RUN, // Timer 1 run control
    output logic UART_RX_DONE_FLAG, // Receive flag
    output logic UART_TX_DONE_FLAG, // Transmit flag
    output logic TIMER2_OVERFLOW_FLAG, // Timer 2 overflow flag
    output logic TIMER2_EXT_EVENT_FLAG // Timer 2 trigger event flag
);
    import irqpu_pkg::*;

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // Index of lowest set bit, which is the fixed tie-break order
    function automatic logic [2:0] first_set(input logic [NUM_SRC-1:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] enab_q, enab_d;
    logic [7:0] prio_q, prio_d;
    logic ext0_pin_q, ext1_pin_q, t2_pin_q;
    logic rx_q, rx_d, tx_q, tx_d, t2ovf_q, t2ovf_d, t2ext_q, t2ext_d;
    logic hi_act_q, hi_act_d, lo_act_q, lo_act_d;
    logic req_q, req_d;
    logic [2:0] idx_q, idx_d;
    logic lvl_q, lvl_d;
    logic [7:0] rdata_q, rdata_d;
    logic [15:0] vec_q, vec_d;
    logic wake_q;

    // ****************************************************************
    // Decoding
    // ****************************************************************
    wire wr_ctrl = SFR_WR && (SFR_ADDR == ADDR_TIMER_IRQ_CONTROL);
    wire wr_enab = SFR_WR && (SFR_ADDR == ADDR_IRQ_ENABLE_MASK);
    wire wr_prio = SFR_WR && (SFR_ADDR == ADDR_IRQ_PRIORITY_SELECT);
    wire ack_ext0 = IRQ_ACK && (idx_q == SRC_EXT0);
    wire ack_ext1 = IRQ_ACK && (idx_q == SRC_EXT1);
    wire ack_t0 = IRQ_ACK && (idx_q == SRC_TIMER0);
    wire ack_t1 = IRQ_ACK && (idx_q == SRC_TIMER1);
    // Falling edges of the active-low external inputs and trigger pin
    wire ext0_fall = ext0_pin_q && !EXT_IRQ0_PIN_N;
    wire ext1_fall = ext1_pin_q && !EXT_IRQ1_PIN_N;
    wire t2_fall = t2_pin_q && !TIMER2_TRIGGER_PIN;
    // In modes with the top mode bit set, the multiprocessor filter drops frames whose ninth bit is zero
    wire rx_block = UART_MODE[UART_MODE_9BIT] && UART_MULTIPROC_FILTER &&
        !UART_RX_NINTH_BIT;
    wire rx_set = UART_RX_EVENT && !rx_block;

    // ****************************************************************
    // Timer and interrupt control register
    // ****************************************************************
    // Hardware sets win over software writes and service clears
    always_comb begin
        ctrl_d = wr_ctrl ? SFR_WDATA : ctrl_q;
        if (ack_ext0) begin
            ctrl_d[CTRL_EXT0_FLAG] = 1'b0;
        end
        if (ack_ext1) begin
            ctrl_d[CTRL_EXT1_FLAG] = 1'b0;
        end
        if (ack_t0) begin
            ctrl_d[CTRL_TIMER0_OVF] = 1'b0;
        end
        if (ack_t1) begin
            ctrl_d[CTRL_TIMER1_OVF] = 1'b0;
        end
        // Level mode follows the pin, edge mode latches a falling edge
        if (!ctrl_q[CTRL_EXT0_TRIG]) begin
            ctrl_d[CTRL_EXT0_FLAG] = !EXT_IRQ0_PIN_N;
        end else if (ext0_fall) begin
            ctrl_d[CTRL_EXT0_FLAG] = 1'b1;
        end
        if (!ctrl_q[CTRL_EXT1_TRIG]) begin
            ctrl_d[CTRL_EXT1_FLAG] = !EXT_IRQ1_PIN_N;
        end else if (ext1_fall) begin
            ctrl_d[CTRL_EXT1_FLAG] = 1'b1;
        end
        if (TIMER0_CARRY) begin
            ctrl_d[CTRL_TIMER0_OVF] = 1'b1;
        end
        if (TIMER1_CARRY) begin
            ctrl_d[CTRL_TIMER1_OVF] = 1'b1;
        end
    end

    // Flags kept outside the register maps, set wins over clear
    assign rx_d = rx_set || (rx_q && !UART_RX_CLR);
    assign tx_d = UART_TX_EVENT || (tx_q && !UART_TX_CLR);
    assign t2ovf_d = TIMER2_CARRY || (t2ovf_q && !TIMER2_OVF_CLR);
    assign t2ext_d = (t2_fall && TIMER2_EXT_EVENT_ENABLE) || (t2ext_q && !TIMER2_EXT_CLR);
    assign enab_d = wr_enab ? SFR_WDATA : enab_q;
    assign prio_d = wr_prio ? SFR_WDATA : prio_q;

    // ****************************************************************
    // Request selection
    // ****************************************************************
    wire [NUM_SRC-1:0] src = {t2ovf_q || t2ext_q, rx_q || tx_q, ctrl_q[CTRL_TIMER1_OVF],
        ctrl_q[CTRL_EXT1_FLAG], ctrl_q[CTRL_TIMER0_OVF], ctrl_q[CTRL_EXT0_FLAG]};
    wire [NUM_SRC-1:0] pend = src & enab_q[NUM_SRC-1:0] & {NUM_SRC{enab_q[BIT_TOP]}};
    // With the priority circuit off, every source is low level
    wire [NUM_SRC-1:0] hi_mask = prio_q[BIT_TOP] ? '0 : prio_q[NUM_SRC-1:0];
    wire [NUM_SRC-1:0] hi_pend = pend & hi_mask;
    wire [NUM_SRC-1:0] lo_pend = pend & ~hi_mask;
    wire hi_ok = !hi_act_q && (|hi_pend);
    wire lo_ok = !hi_act_q && !lo_act_q && (|lo_pend);
    assign req_d = !IRQ_ACK && (hi_ok || lo_ok);
    assign idx_d = hi_ok ? first_set(hi_pend) : first_set(lo_pend);
    assign lvl_d = hi_ok;
    // Vector is registered so that it changes together with the request
    assign vec_d = VECTOR_BASE + ({13'h0000, idx_d} << VECTOR_SHIFT);

    // Service level tracking for nesting
    always_comb begin
        hi_act_d = hi_act_q;
        lo_act_d = lo_act_q;
        if (IRQ_RETURN) begin
            if (hi_act_q) begin
                hi_act_d = 1'b0;
            end else begin
                lo_act_d = 1'b0;
            end
        end
        if (IRQ_ACK && req_q) begin
            if (lvl_q) begin
                hi_act_d = 1'b1;
            end else begin
                lo_act_d = 1'b1;
            end
        end
    end

    // ****************************************************************
    // Register read port
    // ****************************************************************
    wire [7:0] enab_rd = enab_q | (8'h01 << BIT_RESERVED);
    wire [7:0] prio_rd = prio_q | (8'h01 << BIT_RESERVED);
    assign rdata_d = !SFR_RD ? rdata_q :
        (SFR_ADDR == ADDR_TIMER_IRQ_CONTROL) ? ctrl_q :
        (SFR_ADDR == ADDR_IRQ_ENABLE_MASK) ? enab_rd :
        (SFR_ADDR == ADDR_IRQ_PRIORITY_SELECT) ? prio_rd : RDATA_RESET;

    // ****************************************************************
    // Flip-flops
    // ****************************************************************
    // Control and flag state
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            ctrl_q <= CTRL_RESET;
            enab_q <= ENABLE_RESET;
            prio_q <= PRIO_RESET;
            {rx_q, tx_q, t2ovf_q, t2ext_q} <= 4'h0;
            {hi_act_q, lo_act_q} <= 2'h0;
            {ext0_pin_q, ext1_pin_q, t2_pin_q} <= 3'h7;
        end else begin
            ctrl_q <= ctrl_d;
            enab_q <= enab_d;
            prio_q <= prio_d;
            {rx_q, tx_q, t2ovf_q, t2ext_q} <= {rx_d, tx_d, t2ovf_d, t2ext_d};
            {hi_act_q, lo_act_q} <= {hi_act_d, lo_act_d};
            {ext0_pin_q, ext1_pin_q, t2_pin_q} <= {EXT_IRQ0_PIN_N, EXT_IRQ1_PIN_N,
                TIMER2_TRIGGER_PIN};
        end
    end

    // Request, vector, read data and wake outputs
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            req_q <= 1'b0;
            idx_q <= SRC_EXT0;
            vec_q <= VECTOR_BASE;
            lvl_q <= 1'b0;
            rdata_q <= RDATA_RESET;
            wake_q <= 1'b0;
        end else begin
            req_q <= req_d;
            idx_q <= idx_d;
            vec_q <= vec_d;
            lvl_q <= lvl_d;
            rdata_q <= rdata_d;
            wake_q <= IRQ_ACK && req_q;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign SFR_RDATA = rdata_q;
    assign IRQ_REQ = req_q;
    assign IRQ_VECTOR = vec_q;
    assign IDLE_WAKE = wake_q;
    assign RESET_VECTOR = RESET_START;
    assign TIMER0_RUN = ctrl_q[CTRL_TIMER0_RUN];
    assign TIMER1_RUN = ctrl_q[CTRL_TIMER1_RUN];
    assign UART_RX_DONE_FLAG = rx_q;
    assign UART_TX_DONE_FLAG = tx_q;
    assign TIMER2_OVERFLOW_FLAG = t2ovf_q;
    assign TIMER2_EXT_EVENT_FLAG = t2ext_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    chk_edge_latch: assert property (ctrl_q[CTRL_EXT0_TRIG] && ext0_fall |=>
        ctrl_q[CTRL_EXT0_FLAG])
        else $error("edge on external 0 not latched");
    chk_level_follow: assert property (!ctrl_q[CTRL_EXT1_TRIG] |=>
        ctrl_q[CTRL_EXT1_FLAG] == !$past(EXT_IRQ1_PIN_N))
        else $error("level flag does not follow pin");
    chk_timer_set: assert property (TIMER0_CARRY |=> ctrl_q[CTRL_TIMER0_OVF])
        else $error("timer 0 flag not set");
    chk_service_clear: assert property (ack_t1 && !TIMER1_CARRY && !wr_ctrl |=>
        !ctrl_q[CTRL_TIMER1_OVF])
        else $error("timer 1 flag not cleared on service");
    chk_global_block: assert property (!enab_q[BIT_TOP] && !wr_enab |=> !IRQ_REQ)
        else $error("request while globally disabled");
    chk_reserved_one: assert property (SFR_RD |=> SFR_RDATA[BIT_RESERVED] ||
        ($past(SFR_ADDR) != ADDR_IRQ_ENABLE_MASK &&
        $past(SFR_ADDR) != ADDR_IRQ_PRIORITY_SELECT))
        else $error("reserved bit read as zero");
    chk_rx_filter: assert property (UART_RX_EVENT && rx_block && !rx_q |=> !rx_q)
        else $error("filtered frame set receive flag");
    chk_vector_map: assert property (IRQ_REQ |->
        IRQ_VECTOR[2:0] == 3'h3 && IRQ_VECTOR[15:6] == '0)
        else $error("vector outside table");
    chk_wake_pulse: assert property (IRQ_ACK && IRQ_REQ |=>
        IDLE_WAKE ##1 (!IDLE_WAKE || IRQ_ACK))
        else $error("no wake after accept");
    chk_no_nest_high: assert property (hi_act_q |=> !IRQ_REQ)
        else $error("request during high level service");
    chk_t2_sticky: assert property (t2ovf_q && !TIMER2_OVF_CLR |=> t2ovf_q)
        else $error("timer 2 flag lost");
    chk_ack_drop: assert property (IRQ_ACK && IRQ_REQ |=> !IRQ_REQ)
        else $error("request held after accept");
    chk_enable_gate: assert property ($past(enab_q[NUM_SRC-1:0]) == '0 |-> !IRQ_REQ)
        else $error("request with all sources disabled");
    chk_wake_cause: assert property (IDLE_WAKE |-> $past(IRQ_ACK && IRQ_REQ))
        else $error("wake without accept");
    chk_rx_set: assert property (rx_set |=> UART_RX_DONE_FLAG)
        else $error("receive flag not set");
    chk_tx_set: assert property (UART_TX_EVENT |=> UART_TX_DONE_FLAG)
        else $error("transmit flag not set");
    chk_flat_level: assert property (prio_q[BIT_TOP] |=> !lvl_q)
        else $error("high level with priority circuit bit set");

    cov_high_preempt: cover property (lo_act_q && IRQ_REQ && lvl_q ##1 IRQ_ACK);
    cov_edge_service: cover property (ctrl_q[CTRL_EXT0_TRIG] && ack_ext0);
    cov_uart_accept: cover property (IRQ_REQ && idx_q == SRC_UART && IRQ_ACK);
    cov_priority_off: cover property (prio_q[BIT_TOP] && IRQ_ACK);
endmodule

// ---- tb/irqpu_core_model.sv ----
`timescale 1ns/100ps
// ****************************************************************
// Processor core model taking vectors and returning from routines
// ****************************************************************
module irqpu_core_model (
    input wire logic clk, // System clock
    input wire logic rst, // Reset, active high
    input wire logic serve_en, // Core takes interrupts
    input wire logic [3:0] ack_dly, // Request cycles before accept
    input wire logic irq_req, // Request from block
    input wire logic [15:0] irq_vector, // Vector shown
    input wire logic idle_wake, // Wake pulse
    output logic irq_ack, // Accept pulse
    output logic irq_return, // End of routine pulse
    output logic [15:0] last_vec, // Vector taken last
    output logic [7:0] n_ack, // Accepts seen
    output logic [7:0] n_wake // Wakes seen
);
    logic [3:0] wcnt;
    logic [3:0] rcnt;
    logic [3:0] depth;
    logic take;
    logic ret;
    // Accept happens only where a request is shown; one return per accept
    assign take = irq_ack && irq_req;
    assign ret = depth != 4'h0 && rcnt == 4'hF;
    // Accept pulse, routine timer and counters
    always_ff @(posedge clk) begin
        if (rst) begin
            {irq_ack, irq_return, wcnt, rcnt, depth} <= '0;
            {last_vec, n_ack, n_wake} <= '0;
        end else begin
            wcnt <= (irq_req && !irq_ack) ? wcnt + 4'h1 : 4'h0;
            irq_ack <= serve_en && irq_req && !irq_ack && wcnt >= ack_dly;
            irq_return <= ret;
            rcnt <= (depth != 4'h0) ? rcnt + 4'h1 : 4'h0;
            depth <= depth + {3'h0, take} - {3'h0, ret};
            n_wake <= n_wake + {7'h0, idle_wake};
            if (take) begin
                last_vec <= irq_vector;
                n_ack <= n_ack + 8'h01;
            end
        end
    end
endmodule

// ---- tb/irqpu_tb_top.sv ----
`timescale 1ns/100ps
// ****************************************************************
// Testbench of the interrupt request and priority unit
// ****************************************************************
module irqpu_tb_top;
    logic sys_clk, rst, we, re, pin0, pin1, trig, t2en, ninth, filt;
    logic serve, ack, ret, wake, req;
    logic [1:0] mode;
    logic [3:0] adly;
    logic [7:0] addr, wdata, rdata, n_ack, n_wake, n0;
    logic [8:0] pul;
    logic [15:0] vec, rvec, last_vec;
    logic rxf, txf, ovf, evf, run0, run1;
    logic [8:0] msk [6] = '{9'h000, 9'h001, 9'h000, 9'h002, 9'h020, 9'h004};
    int n_fail = 0;
    int total_checks = 0;

    irqpu_top u_irqpu_top (.SYS_CLK(sys_clk), .RESET(rst), .SFR_ADDR(addr), .SFR_WR(we),
        .SFR_WDATA(wdata), .SFR_RD(re), .SFR_RDATA(rdata), .EXT_IRQ0_PIN_N(pin0),
        .EXT_IRQ1_PIN_N(pin1), .TIMER0_CARRY(pul[0]), .TIMER1_CARRY(pul[1]),
        .TIMER2_CARRY(pul[2]), .TIMER2_TRIGGER_PIN(trig), .TIMER2_EXT_EVENT_ENABLE(t2en),
        .TIMER2_OVF_CLR(pul[3]), .TIMER2_EXT_CLR(pul[4]), .UART_RX_EVENT(pul[5]),
        .UART_RX_NINTH_BIT(ninth), .UART_MULTIPROC_FILTER(filt), .UART_MODE(mode),
        .UART_RX_CLR(pul[6]), .UART_TX_EVENT(pul[7]), .UART_TX_CLR(pul[8]), .IRQ_ACK(ack),
        .IRQ_RETURN(ret), .IRQ_REQ(req), .IRQ_VECTOR(vec), .IDLE_WAKE(wake),
        .RESET_VECTOR(rvec), .TIMER0_RUN(run0), .TIMER1_RUN(run1), .UART_RX_DONE_FLAG(rxf),
        .UART_TX_DONE_FLAG(txf), .TIMER2_OVERFLOW_FLAG(ovf), .TIMER2_EXT_EVENT_FLAG(evf));

    irqpu_core_model u_irqpu_core_model (.clk(sys_clk), .rst(rst), .serve_en(serve),
        .ack_dly(adly), .irq_req(req), .irq_vector(vec), .idle_wake(wake), .irq_ack(ack),
        .irq_return(ret), .last_vec(last_vec), .n_ack(n_ack), .n_wake(n_wake));

    // ****************************************************************
    // Clock and shared tasks
    // ****************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic stop_test();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            $display("FAIL %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge sys_clk);
        we <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        addr <= a;
        re <= 1'b1;
        @(posedge sys_clk);
        re <= 1'b0;
        #1 chk("read data", {8'h00, e}, {8'h00, rdata});
    endtask

    task automatic pulse(input logic [8:0] m);
        @(posedge sys_clk);
        pul <= m;
        @(posedge sys_clk);
        pul <= '0;
    endtask

    task automatic waitack();
        int k;
        k = 0;
        while (n_ack === n0 && k < 60) begin
            @(posedge sys_clk);
            #1 k++;
        end
        if (n_ack === n0) begin
            $display("FAIL accept count expected change seen %h", n_ack);
            n_fail++;
            stop_test();
        end
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {rst, serve, adly} <= {1'b1, 1'b1, 4'h0};
        {we, re, addr, wdata, pul, trig, t2en} <= {2'b00, 16'h0000, 9'h000, 2'b10};
        {pin0, pin1, ninth, filt, mode} <= {2'b11, 2'b00, 2'b00};
        tick(6);
        rst <= 1'b0;
        #1 chk("reset vector", 16'h0000, rvec);
        rd(8'h88, 8'h00);
        rd(8'hA8, 8'h40);
        rd(8'hB8, 8'h40);
        rd(8'h90, 8'h00);
        wr(8'hA8, 8'hBF);
        rd(8'hA8, 8'hFF);
        wr(8'hB8, 8'h3F);
        rd(8'hB8, 8'h7F);
        wr(8'hB8, 8'h00);
        wr(8'hA8, 8'h3F);
        n0 = n_ack;
        pulse(9'h001);
        tick(6);
        #1 chk("request masked", 16'h0000, {15'h0, req});
        rd(8'h88, 8'h20);
        wr(8'hA8, 8'h82);
        waitack();
        chk("vector", 16'h000B, last_vec);
        tick(2);
        rd(8'h88, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr(8'hA8, 8'h80 | (8'h01 << i));
            n0 = n_ack;
            case (i)
                0: pin0 <= 1'b0;
                2: pin1 <= 1'b0;
                default: pulse(msk[i]);
            endcase
            waitack();
            chk("vector", 16'h0003 + 16'(8 * i), last_vec);
            @(posedge sys_clk);
            {pin0, pin1} <= 2'b11;
            if (i == 4) chk("rx flag", 16'h0001, {15'h0, rxf});
            if (i == 5) chk("overflow flag", 16'h0001, {15'h0, ovf});
            pulse(9'h048);
            tick(40);
        end
        // Tie order, priority level and the priority-circuit bit
        serve <= 1'b0;
        wr(8'hA8, 8'h8A);
        pulse(9'h003);
        tick(3);
        #1 chk("tie vector", 16'h000B, vec);
        wr(8'hB8, 8'h08);
        tick(2);
        #1 chk("high vector", 16'h001B, vec);
        wr(8'hB8, 8'h88);
        tick(2);
        #1 chk("flat vector", 16'h000B, vec);
        {serve, adly} <= {1'b1, 4'h3};
        tick(60);
        rd(8'h88, 8'h00);
        // A high-level request interrupts a low-level routine
        wr(8'hB8, 8'h08);
        adly <= 4'h0;
        n0 = n_ack;
        pulse(9'h001);
        waitack();
        n0 = n_ack;
        pulse(9'h002);
        waitack();
        chk("nested vector", 16'h001B, last_vec);
        tick(60);
        chk("wake count", {8'h00, n_ack}, {8'h00, n_wake});
        // Edge mode takes one request for a pin held low
        serve <= 1'b0;
        wr(8'h88, 8'h51);
        pin0 <= 1'b0;
        tick(3);
        rd(8'h88, 8'h53);
        chk("run bits", 16'h0003, {14'h0, run1, run0});
        n0 = n_ack;
        wr(8'hA8, 8'h81);
        serve <= 1'b1;
        waitack();
        tick(3);
        rd(8'h88, 8'h51);
        pin0 <= 1'b1;
        // Serial flags and the multiprocessor filter
        {serve, mode, filt} <= {1'b0, 2'b10, 1'b1};
        pulse(9'h020);
        tick(2);
        #1 chk("filtered rx", 16'h0000, {15'h0, rxf});
        ninth <= 1'b1;
        pulse(9'h0A0);
        tick(2);
        #1 chk("rx tx flags", 16'h0003, {14'h0, txf, rxf});
        pulse(9'h140);
        tick(2);
        #1 chk("cleared flags", 16'h0000, {14'h0, txf, rxf});
        // Trigger pin falling edge, with and without its enable
        t2en <= 1'b1;
        tick(1);
        trig <= 1'b0;
        tick(3);
        #1 chk("trigger flag", 16'h0001, {15'h0, evf});
        pulse(9'h010);
        {trig, t2en} <= 2'b10;
        tick(1);
        trig <= 1'b0;
        tick(3);
        #1 chk("gated trigger", 16'h0000, {15'h0, evf});
        stop_test();
    end
endmodule
